// ===== hdl/dcd_sync_err_cnt.sv
// Saturating error counter for invalid master sync telegrams
`timescale 1ns/1ns
`default_nettype none
module dcd_sync_err_cnt (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire dcd_pkg::dcd_tel_t tel,
    input  wire logic [2:0]    comm_phase,
    output var  logic [15:0]   count_q,
    output var  logic          inc_q,
    output var  logic          sat_q
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [1:0]  run_q;
    logic        in_phase;
    logic        do_inc;

    assign in_phase = (comm_phase == dcd_pkg::PHASE_THREE) ||
                      (comm_phase == dcd_pkg::PHASE_FOUR);        // [RL11]
    assign do_inc = tel.invalid && in_phase &&
                    (run_q < dcd_pkg::RUN_LIMIT) &&               // [RL12]
                    (count_q != dcd_pkg::CNT_MAX);                // [RL13]

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 16'h0000;                                  // [RL14]
            run_q   <= 2'h0;
            inc_q   <= 1'b0;
            sat_q   <= 1'b0;
        end else begin
            inc_q <= do_inc;
            sat_q <= do_inc && (count_q == dcd_pkg::CNT_MAX - 16'h0001);
            if (do_inc)
                count_q <= count_q + 16'h0001;
            if (tel.valid)
                run_q <= 2'h0;                                    // [RL14]
            else if (tel.invalid && run_q < dcd_pkg::RUN_LIMIT)
                run_q <= run_q + 2'h1;
        end
    end

    chk_count_phase: assert property ( // [RL11]
        count_q != $past(count_q) |-> $past(tel.invalid && in_phase))
        else $error("count moved without an invalid telegram in phase");
    chk_run_limit: assert property ( // [RL12]
        tel.invalid && run_q == dcd_pkg::RUN_LIMIT |=> $stable(count_q))
        else $error("third consecutive invalid telegram was counted");
    chk_count_sat: assert property ( // [RL13]
        $past(count_q) == dcd_pkg::CNT_MAX |-> count_q == dcd_pkg::CNT_MAX)
        else $error("error counter wrapped");
    chk_count_reset: assert property ( // [RL14]
        $past(rst) |-> count_q == 16'h0000)
        else $error("counter not cleared by reset");
    cov_count_inc: cover property (inc_q);
endmodule : dcd_sync_err_cnt
`default_nettype wire

// ===== hdl/dcd_top.sv
// Drive cyclic config lists, signal word mapping and sync error diagnostics
// How it works
// [RL1] On entering phase four the drive lists identifiers of invalid parameters.
// [RL2] Master data list holds cyclic identifiers in telegram order.
// [RL3] Master data list entries not in the configurable list are rejected.
// [RL4] Master data list exists only while the application telegram is allowed.
// [RL5] A read-only list gives every implemented procedure command identifier.
// [RL6] Status word bit order follows status list order, first entry bit 0.
// [RL7] Status list takes at most sixteen entries, last one is bit 15.
// [RL8] Control word bits go to list parameters in order, first at bit 0.
// [RL9] Control list takes at most sixteen entries, last one is bit 15.
// [RL10] Without bit selection support, bit 0 of the parameter is used.
// [RL11] Invalid sync telegrams are counted only in phases three and four.
// [RL12] Only the first two of consecutive invalid sync telegrams count.
// [RL13] Sync error counter is 16 bits and saturates at its maximum.
// [RL14] Counter clears at reset; a valid telegram ends an invalid run.
`timescale 1ns/1ns
`default_nettype none
module dcd_top #(
    parameter bit BIT_SEL_EN = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    output var  logic        irq,
    input  wire logic [2:0]  comm_phase,
    input  wire dcd_pkg::dcd_tel_t master_sync_telegram,
    input  wire logic [dcd_pkg::NPAR-1:0][15:0] param_val,
    input  wire logic [dcd_pkg::NPAR-1:0]       param_invalid,
    input  wire logic [15:0] ctrl_word,
    input  wire logic        ctrl_word_valid,
    output var  logic [15:0] status_word_q,
    output var  logic [dcd_pkg::NPAR-1:0][15:0] ctrl_param_q
);
    // All checks share this clock and reset
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    typedef enum logic [1:0] {
        DCD_IDLE = 2'b01,
        DCD_SCAN = 2'b10
    } dcd_scan_t;

    // Parameter lookup by identifier: {found, index}
    function automatic logic [dcd_pkg::IDX_W:0] find_param(
        input logic [15:0] ident
    );
        logic [dcd_pkg::IDX_W:0] r;
        r = '0;
        for (int p = 0; p < dcd_pkg::NPAR; p++) begin
            if (dcd_pkg::PARAM_IDENT[p] == ident)
                r = {1'b1, p[dcd_pkg::IDX_W-1:0]};
        end
        return r;
    endfunction : find_param

    // Effective bit within a parameter
    function automatic logic [3:0] eff_sel(input logic [3:0] sel);
        return BIT_SEL_EN ? sel : 4'h0;                          // [RL10]
    endfunction : eff_sel

    logic [31:0]           ctrl_q;
    logic [dcd_pkg::IRQ_W-1:0] irq_stat_q;
    logic [dcd_pkg::IRQ_W-1:0] irq_mask_q;
    logic [15:0]           mdt_list_q  [dcd_pkg::LIST_DEPTH];
    logic [15:0]           inv_list_q  [dcd_pkg::LIST_DEPTH];
    dcd_pkg::dcd_map_t     stat_map_q  [dcd_pkg::LIST_DEPTH];
    dcd_pkg::dcd_map_t     ctrl_map_q  [dcd_pkg::LIST_DEPTH];
    logic [4:0]            mdt_len_q;
    logic [4:0]            stat_len_q;
    logic [4:0]            ctrl_len_q;
    logic [4:0]            inv_len_q;
    logic [dcd_pkg::IDX_W-1:0] scan_idx_q;
    dcd_scan_t             scan_q;
    logic [2:0]            phase_prev_q;
    logic [15:0]           sync_cnt;
    logic                  cnt_inc;
    logic                  cnt_sat;

    // Bus decode
    wire        req      = avs_read || avs_write;
    wire        wr_acc   = avs_write && !avs_waitrequest;
    wire [4:0]  rgn      = avs_address[11:7];
    wire [3:0]  ent      = avs_address[5:2];
    wire        ent_ok   = !avs_address[6];
    wire        app_on   = ctrl_q[dcd_pkg::CTRL_APP_BIT];
    wire [15:0] wr_ident = avs_writedata[15:0];
    wire [3:0]  wr_sel   = avs_writedata[dcd_pkg::SEL_LSB +: 4];
    wire [dcd_pkg::IDX_W:0] wr_hit = find_param(wr_ident);
    wire        wr_mdt_ok = wr_hit[dcd_pkg::IDX_W] &&
                    dcd_pkg::PARAM_MDT_OK[wr_hit[dcd_pkg::IDX_W-1:0]];
    wire        is_reg   = rgn == dcd_pkg::RGN_REGS;
    wire        we_ctrl  = wr_acc && avs_address == dcd_pkg::OFS_CTRL;
    wire        we_istat = wr_acc && avs_address == dcd_pkg::OFS_IRQ_STAT;
    wire        we_imask = wr_acc && avs_address == dcd_pkg::OFS_IRQ_MASK;
    wire        we_len   = wr_acc && avs_address == dcd_pkg::OFS_LEN;
    wire        we_mdt   = wr_acc && ent_ok && app_on &&
                           rgn == dcd_pkg::RGN_MDT;               // [RL4]
    wire        we_stat  = wr_acc && ent_ok && rgn == dcd_pkg::RGN_STAT;
    wire        we_cmap  = wr_acc && ent_ok && rgn == dcd_pkg::RGN_CTRLMAP;

    // Length fields: more than sixteen entries is refused
    wire [4:0]  wl_mdt   = avs_writedata[dcd_pkg::LEN_MDT_LSB +: 5];
    wire [4:0]  wl_stat  = avs_writedata[dcd_pkg::LEN_STAT_LSB +: 5];
    wire [4:0]  wl_ctrl  = avs_writedata[dcd_pkg::LEN_CTRL_LSB +: 5];
    wire        len_ok   = wl_mdt <= dcd_pkg::LEN_MAX &&
                           wl_stat <= dcd_pkg::LEN_MAX &&          // [RL7]
                           wl_ctrl <= dcd_pkg::LEN_MAX;            // [RL9]
    wire        rej_mdt  = we_mdt && !wr_mdt_ok;                   // [RL3]
    wire        rej_map  = (we_stat || we_cmap) && !wr_hit[dcd_pkg::IDX_W];
    wire        rej_ev   = rej_mdt || rej_map || (we_len && !len_ok);

    // Interrupt events: set wins over write-one-to-clear
    wire [dcd_pkg::IRQ_W-1:0] ev = {cnt_sat, rej_ev, cnt_inc};
    wire [dcd_pkg::IRQ_W-1:0] irq_clr =
        we_istat ? avs_writedata[dcd_pkg::IRQ_W-1:0] : '0;
    wire [dcd_pkg::IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | ev;

    // Read mux
    wire [15:0] proc_rd  = ent < 4'(dcd_pkg::NPROC) ?
                           dcd_pkg::PROC_IDENT[ent[1:0]] : 16'h0000; // [RL5]
    wire [15:0] mdtok_rd = (ent < 4'(dcd_pkg::NPAR) &&
                            dcd_pkg::PARAM_MDT_OK[ent[dcd_pkg::IDX_W-1:0]]) ?
                           dcd_pkg::PARAM_IDENT[ent[dcd_pkg::IDX_W-1:0]] :
                           16'h0000;
    wire [31:0] map_rd_s = {12'h000, stat_map_q[ent].sel,
                            stat_map_q[ent].valid ?
                            dcd_pkg::PARAM_IDENT[stat_map_q[ent].idx] :
                            16'h0000};
    wire [31:0] map_rd_c = {12'h000, ctrl_map_q[ent].sel,
                            ctrl_map_q[ent].valid ?
                            dcd_pkg::PARAM_IDENT[ctrl_map_q[ent].idx] :
                            16'h0000};
    wire [31:0] reg_rd =
        avs_address == dcd_pkg::OFS_CTRL     ? ctrl_q :
        avs_address == dcd_pkg::OFS_IRQ_STAT ? 32'(irq_stat_q) :
        avs_address == dcd_pkg::OFS_IRQ_MASK ? 32'(irq_mask_q) :
        avs_address == dcd_pkg::OFS_SYNC_ERR ? {16'h0000, sync_cnt} :
        avs_address == dcd_pkg::OFS_LEN      ?
            {11'h000, ctrl_len_q, 3'h0, stat_len_q, 3'h0, mdt_len_q} :
        avs_address == dcd_pkg::OFS_INV_LEN  ?
            {23'h000000, scan_q == DCD_SCAN, 3'h0, inv_len_q} :
        32'h0000_0000;
    wire [31:0] rd_mux =
        is_reg                        ? reg_rd :
        !ent_ok                       ? 32'h0000_0000 :
        rgn == dcd_pkg::RGN_MDT       ?
            (app_on ? {16'h0000, mdt_list_q[ent]} : 32'h0000_0000) :
        rgn == dcd_pkg::RGN_INVALID   ? {16'h0000, inv_list_q[ent]} :
        rgn == dcd_pkg::RGN_STAT      ? map_rd_s :
        rgn == dcd_pkg::RGN_CTRLMAP   ? map_rd_c :
        rgn == dcd_pkg::RGN_PROC      ? {16'h0000, proc_rd} :
        rgn == dcd_pkg::RGN_MDT_OK    ? {16'h0000, mdtok_rd} :
        32'h0000_0000;

    // One wait state per access; read data latched in the wait cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (avs_read && avs_waitrequest)
                avs_readdata <= rd_mux;
        end
    end

    // Control and interrupt registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q     <= dcd_pkg::CTRL_RESET;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq        <= 1'b0;
            mdt_len_q  <= 5'h00;
            stat_len_q <= 5'h00;
            ctrl_len_q <= 5'h00;
        end else begin
            if (we_ctrl)
                ctrl_q <= {31'h0, avs_writedata[dcd_pkg::CTRL_APP_BIT]};
            if (we_imask)
                irq_mask_q <= avs_writedata[dcd_pkg::IRQ_W-1:0];
            irq_stat_q <= irq_stat_d;
            irq        <= |(irq_stat_d & (we_imask ?
                          avs_writedata[dcd_pkg::IRQ_W-1:0] : irq_mask_q));
            if (we_len && len_ok) begin
                mdt_len_q  <= wl_mdt;
                stat_len_q <= wl_stat;
                ctrl_len_q <= wl_ctrl;
            end
        end
    end

    // List storage; list order is the telegram and bit order
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < dcd_pkg::LIST_DEPTH; i++) begin
                mdt_list_q[i] <= 16'h0000;
                stat_map_q[i] <= '0;
                ctrl_map_q[i] <= '0;
            end
        end else begin
            if (we_mdt && wr_mdt_ok)
                mdt_list_q[ent] <= wr_ident;                      // [RL2] [RL3]
            if (we_stat && wr_hit[dcd_pkg::IDX_W])
                stat_map_q[ent] <= {1'b1, wr_hit[dcd_pkg::IDX_W-1:0],
                                    eff_sel(wr_sel)};             // [RL6]
            if (we_cmap && wr_hit[dcd_pkg::IDX_W])
                ctrl_map_q[ent] <= {1'b1, wr_hit[dcd_pkg::IDX_W-1:0],
                                    eff_sel(wr_sel)};             // [RL8]
        end
    end

    // Invalid-data scan on entry into phase four
    wire enter_four = comm_phase == dcd_pkg::PHASE_FOUR &&
                      phase_prev_q != dcd_pkg::PHASE_FOUR;
    wire scan_last  = scan_idx_q == dcd_pkg::IDX_W'(dcd_pkg::NPAR - 1);
    // Hits past sixteen entries are dropped
    wire scan_hit   = scan_q == DCD_SCAN && param_invalid[scan_idx_q] &&
                      inv_len_q < dcd_pkg::LEN_MAX;

    always_ff @(posedge clk) begin
        if (rst) begin
            scan_q       <= DCD_IDLE;
            scan_idx_q   <= '0;
            inv_len_q    <= 5'h00;
            phase_prev_q <= 3'h0;
            for (int i = 0; i < dcd_pkg::LIST_DEPTH; i++)
                inv_list_q[i] <= 16'h0000;
        end else begin
            phase_prev_q <= comm_phase;
            case (scan_q)
                DCD_IDLE: begin
                    if (enter_four) begin
                        scan_q     <= DCD_SCAN;                   // [RL1]
                        scan_idx_q <= '0;
                        inv_len_q  <= 5'h00;
                    end
                end
                DCD_SCAN: begin
                    if (scan_hit) begin
                        inv_list_q[inv_len_q[3:0]] <=
                            dcd_pkg::PARAM_IDENT[scan_idx_q];     // [RL1]
                        inv_len_q <= inv_len_q + 5'h01;
                    end
                    scan_idx_q <= scan_idx_q + 1'b1;
                    if (scan_last)
                        scan_q <= DCD_IDLE;
                end
                default: scan_q <= DCD_IDLE;
            endcase
        end
    end

    // Signal status word assembly and control word distribution
    logic [15:0] status_d;
    logic [dcd_pkg::NPAR-1:0][15:0] ctrl_param_d;
    always_comb begin
        status_d     = 16'h0000;
        ctrl_param_d = ctrl_param_q;
        for (int i = 0; i < dcd_pkg::LIST_DEPTH; i++) begin
            if (5'(i) < stat_len_q && stat_map_q[i].valid)
                status_d[i] = param_val[stat_map_q[i].idx]
                                       [eff_sel(stat_map_q[i].sel)]; // [RL6] [RL7]
            if (ctrl_word_valid && 5'(i) < ctrl_len_q && ctrl_map_q[i].valid)
                ctrl_param_d[ctrl_map_q[i].idx]
                            [eff_sel(ctrl_map_q[i].sel)] = ctrl_word[i]; // [RL8] [RL9]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_word_q <= 16'h0000;
            ctrl_param_q  <= '0;
        end else begin
            status_word_q <= status_d;
            ctrl_param_q  <= ctrl_param_d;
        end
    end

    dcd_sync_err_cnt u_sync_cnt (
        .clk        (clk),
        .rst        (rst),
        .tel        (master_sync_telegram),
        .comm_phase (comm_phase),
        .count_q    (sync_cnt),
        .inc_q      (cnt_inc),
        .sat_q      (cnt_sat)
    );

    // Bus protocol and rule checks
    chk_scan_start: assert property ( // [RL1]
        scan_q == DCD_IDLE && enter_four |=> scan_q == DCD_SCAN ##[7:7]
        scan_q == DCD_SCAN ##1 scan_q == DCD_IDLE)
        else $error("invalid list scan did not run one pass");
    chk_mdt_reject: assert property ( // [RL3]
        we_mdt && !wr_mdt_ok |=>
        mdt_list_q[$past(ent)] == $past(mdt_list_q[ent]))
        else $error("non-configurable identifier stored");
    chk_mdt_app_off: assert property ( // [RL4]
        avs_read && avs_waitrequest && rgn == dcd_pkg::RGN_MDT && !app_on
        |=> avs_readdata == 32'h0000_0000)
        else $error("master data list readable with application off");
    chk_status_first: assert property ( // [RL6] [RL10]
        stat_len_q != 5'h00 && stat_map_q[0].valid |=>
        status_word_q[0] ==
        $past(param_val[stat_map_q[0].idx][eff_sel(stat_map_q[0].sel)]))
        else $error("first status entry not at its bit");
    chk_status_empty: assert property ( // [RL6]
        stat_len_q == 5'h00 |=> status_word_q == 16'h0000)
        else $error("status bits set with an empty list");
    chk_len_limit: assert property ( // [RL7] [RL9]
        stat_len_q <= dcd_pkg::LEN_MAX && ctrl_len_q <= dcd_pkg::LEN_MAX)
        else $error("mapping longer than sixteen entries");
    chk_len_refused: assert property ( // [RL7] [RL9]
        we_len && !len_ok |=> $stable(stat_len_q) && $stable(ctrl_len_q))
        else $error("over-long mapping length stored");
    chk_ctrl_hold: assert property ( // [RL8]
        !ctrl_word_valid |=> $stable(ctrl_param_q))
        else $error("control bits moved without a valid word");
    chk_wait_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");
    chk_irq_level: assert property (
        irq == |(irq_stat_q & irq_mask_q))
        else $error("interrupt level differs from unmasked status");

    // Main scenarios
    cov_ctrl_word: cover property (@(posedge clk) disable iff (rst)
        ctrl_word_valid && ctrl_len_q == dcd_pkg::LEN_MAX);
    cov_reject: cover property (@(posedge clk) disable iff (rst) rej_mdt);
    cov_scan_hit: cover property (scan_hit);
    cov_len_refused: cover property (we_len && !len_ok);
endmodule : dcd_top
`default_nettype wire

// ===== shared/dcd_pkg.sv
// Constants, parameter tables and carrier types for drive config/diagnostics
package dcd_pkg;
    localparam int          NPAR       = 8;
    localparam int          IDX_W      = 3;
    localparam int          LIST_DEPTH = 16;
    localparam int          NPROC      = 4;

    // Parameter identifiers known to the drive (values arbitrary)
    localparam logic [15:0] PARAM_IDENT [NPAR] = '{
        16'h0101, 16'h0102, 16'h0103, 16'h0104,
        16'h0105, 16'h0106, 16'h0107, 16'h0108};
    // Which of them may be carried in the master data telegram
    localparam logic [NPAR-1:0] PARAM_MDT_OK = 8'h0F;
    // Procedure commands implemented (values arbitrary)
    localparam logic [15:0] PROC_IDENT [NPROC] = '{
        16'h0201, 16'h0202, 16'h0203, 16'h0204};

    localparam logic [2:0]  PHASE_THREE = 3'h3;
    localparam logic [2:0]  PHASE_FOUR  = 3'h4;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [1:0]  RUN_LIMIT   = 2'h2;
    localparam logic [4:0]  LEN_MAX     = 5'h10;

    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h004;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
    localparam logic [11:0] OFS_SYNC_ERR = 12'h00C;
    localparam logic [11:0] OFS_LEN      = 12'h010;
    localparam logic [11:0] OFS_INV_LEN  = 12'h014;
    // List regions, selected by address bits 11:7
    localparam logic [4:0]  RGN_REGS     = 5'h00;
    localparam logic [4:0]  RGN_MDT      = 5'h02;
    localparam logic [4:0]  RGN_INVALID  = 5'h04;
    localparam logic [4:0]  RGN_STAT     = 5'h06;
    localparam logic [4:0]  RGN_CTRLMAP  = 5'h07;
    localparam logic [4:0]  RGN_PROC     = 5'h08;
    localparam logic [4:0]  RGN_MDT_OK   = 5'h09;

    // Field positions
    localparam int          CTRL_APP_BIT = 0;
    localparam int          IRQ_INC_BIT  = 0;
    localparam int          IRQ_REJ_BIT  = 1;
    localparam int          IRQ_SAT_BIT  = 2;
    localparam int          IRQ_W        = 3;
    localparam int          LEN_MDT_LSB  = 0;
    localparam int          LEN_STAT_LSB = 8;
    localparam int          LEN_CTRL_LSB = 16;
    localparam int          INV_BUSY_BIT = 8;
    localparam int          SEL_LSB      = 16;

    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

    typedef struct packed {
        logic             valid;
        logic [IDX_W-1:0] idx;
        logic [3:0]       sel;
    } dcd_map_t;

    typedef struct packed {
        logic valid;
        logic invalid;
    } dcd_tel_t;
endpackage : dcd_pkg

// ===== testbench/dcd_master_model.sv
// Behavioural master control unit: sync telegrams and control words
`timescale 1ns/1ns
`default_nettype none
module dcd_master_model (
    input  wire logic              clk,
    output var  dcd_pkg::dcd_tel_t sync_tel,
    output var  logic [15:0]       ctrl_word,
    output var  logic              ctrl_word_valid
);
    initial begin
        sync_tel        = '0;
        ctrl_word       = 16'h0000;
        ctrl_word_valid = 1'b0;
    end
    // One telegram pulse, then an idle cycle
    task automatic send_sync(input logic bad);
        sync_tel.valid   <= ~bad;
        sync_tel.invalid <= bad;
        @(posedge clk);
        sync_tel <= '0;
        @(posedge clk);
    endtask : send_sync
    // Word is garbled outside its valid cycle
    task automatic send_ctrl(input logic [15:0] w);
        ctrl_word       <= w;
        ctrl_word_valid <= 1'b1;
        @(posedge clk);
        ctrl_word       <= ~w;
        ctrl_word_valid <= 1'b0;
        @(posedge clk);
    endtask : send_ctrl
endmodule : dcd_master_model
`default_nettype wire

// ===== testbench/drive_cyclic_config_diag_tb.sv
// Self-checking bench for the drive config and diagnostics block
`timescale 1ns/1ns
`default_nettype none
module drive_cyclic_config_diag_tb;
    logic                               clk;
    logic                               rst;
    logic [11:0]                        avs_address;
    logic                               avs_read;
    logic                               avs_write;
    logic [31:0]                        avs_writedata;
    logic [31:0]                        avs_readdata;
    logic                               avs_waitrequest;
    logic                               irq;
    logic [2:0]                         comm_phase;
    dcd_pkg::dcd_tel_t                  sync_tel;
    logic [dcd_pkg::NPAR-1:0][15:0]     param_val;
    logic [dcd_pkg::NPAR-1:0]           param_invalid;
    logic [15:0]                        ctrl_word;
    logic                               ctrl_word_valid;
    logic [15:0]                        status_word_q;
    logic [dcd_pkg::NPAR-1:0][15:0]     ctrl_param_q;
    logic [31:0]                        rd;
    int                                 failures;
    int                                 n_compared;

    dcd_top uut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq),
        .comm_phase(comm_phase), .master_sync_telegram(sync_tel),
        .param_val(param_val), .param_invalid(param_invalid),
        .ctrl_word(ctrl_word), .ctrl_word_valid(ctrl_word_valid),
        .status_word_q(status_word_q), .ctrl_param_q(ctrl_param_q));

    dcd_master_model u_mst (.clk(clk), .sync_tel(sync_tel),
        .ctrl_word(ctrl_word), .ctrl_word_valid(ctrl_word_valid));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask : rd_chk

    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        failures = 0;
        n_compared = 0;
        rst = 1'b1;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        comm_phase = 3'h0;
        param_val = '0;
        param_invalid = 8'h22;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk("count at reset", dcd_pkg::OFS_SYNC_ERR, 32'h0);
        rd_chk("unmapped", 12'h018, 32'h0);
        for (int i = 0; i < dcd_pkg::NPROC; i++)
            rd_chk("proc list", 12'h400 + 12'(4*i),
                   {16'h0, dcd_pkg::PROC_IDENT[i]});
        for (int i = 0; i < dcd_pkg::NPAR; i++)
            rd_chk("mdt ok list", 12'h480 + 12'(4*i),
                   dcd_pkg::PARAM_MDT_OK[i] ?
                   {16'h0, dcd_pkg::PARAM_IDENT[i]} : 32'h0);
        bus(1'b1, 12'h100, {16'h0, dcd_pkg::PARAM_IDENT[0]});
        rd_chk("mdt app off", 12'h100, 32'h0);
        bus(1'b1, dcd_pkg::OFS_CTRL, 32'h0000_0001);
        bus(1'b1, 12'h100, {16'h0, dcd_pkg::PARAM_IDENT[0]});
        rd_chk("mdt entry", 12'h100, {16'h0, dcd_pkg::PARAM_IDENT[0]});
        bus(1'b1, 12'h104, {16'h0, dcd_pkg::PARAM_IDENT[5]});
        rd_chk("mdt reject", 12'h104, 32'h0);
        rd_chk("reject flag", dcd_pkg::OFS_IRQ_STAT, 32'h2);
        // Status map: first entry param 2 bit 3, last entry param 1 bit 0
        bus(1'b1, 12'h300, {12'h0, 4'h3, dcd_pkg::PARAM_IDENT[2]});
        bus(1'b1, 12'h33C, {12'h0, 4'h0, dcd_pkg::PARAM_IDENT[1]});
        bus(1'b1, 12'h380, {12'h0, 4'h5, dcd_pkg::PARAM_IDENT[3]});
        bus(1'b1, 12'h3BC, {12'h0, 4'h2, dcd_pkg::PARAM_IDENT[4]});
        bus(1'b1, dcd_pkg::OFS_LEN, 32'h0010_1001);
        bus(1'b1, dcd_pkg::OFS_LEN, 32'h0000_1100);
        rd_chk("len after refusal", dcd_pkg::OFS_LEN, 32'h0010_1001);
        param_val <= {{5{16'hFFFF}}, 16'h0008, 16'h0001, 16'hFFFF};
        repeat (3) @(posedge clk);
        check("status word", {16'h0, status_word_q}, 32'h8001);
        param_val[2] <= 16'hFFF7;
        param_val[1] <= 16'hFFFE;
        repeat (2) @(posedge clk);
        check("status low", {16'h0, status_word_q}, 32'h0);
        u_mst.send_ctrl(16'h8001);
        check("ctrl first", {16'h0, ctrl_param_q[3]}, 32'h0020);
        check("ctrl last", {16'h0, ctrl_param_q[4]}, 32'h0004);
        // Sync error counting across phases
        bus(1'b1, dcd_pkg::OFS_IRQ_STAT, 32'h0000_0007);
        bus(1'b1, dcd_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        comm_phase <= 3'h2;
        u_mst.send_sync(1'b1);
        rd_chk("count phase two", dcd_pkg::OFS_SYNC_ERR, 32'h0);
        check("irq idle", {31'h0, irq}, 32'h0);
        comm_phase <= 3'h3;
        u_mst.send_sync(1'b0);
        repeat (3) u_mst.send_sync(1'b1);
        rd_chk("count run", dcd_pkg::OFS_SYNC_ERR, 32'h2);
        check("irq raised", {31'h0, irq}, 32'h1);
        u_mst.send_sync(1'b0);
        u_mst.send_sync(1'b1);
        rd_chk("count new run", dcd_pkg::OFS_SYNC_ERR, 32'h3);
        bus(1'b1, dcd_pkg::OFS_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        comm_phase <= 3'h4;
        repeat (12) @(posedge clk);
        rd_chk("invalid len", dcd_pkg::OFS_INV_LEN, 32'h2);
        rd_chk("invalid 0", 12'h200, {16'h0, dcd_pkg::PARAM_IDENT[1]});
        rd_chk("invalid 1", 12'h204, {16'h0, dcd_pkg::PARAM_IDENT[5]});
        u_mst.send_sync(1'b1);
        rd_chk("count phase four", dcd_pkg::OFS_SYNC_ERR, 32'h4);
        param_invalid <= 8'h81;
        comm_phase    <= 3'h3;
        @(posedge clk);
        comm_phase    <= 3'h4;
        repeat (12) @(posedge clk);
        rd_chk("rescan len", dcd_pkg::OFS_INV_LEN, 32'h2);
        rd_chk("rescan", 12'h204, {16'h0, dcd_pkg::PARAM_IDENT[7]});
        tally_and_finish();
    end
endmodule : drive_cyclic_config_diag_tb
`default_nettype wire
